// ---- bench/igc_bus_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module igc_bus_monitor (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // bus signals
    input wire logic scl_m_oe,
    input wire logic sda_m_oe,
    input wire logic sda_s_oe,
    input wire logic scl,
    input wire logic sda
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    sequence s_start;
        scl && $past(scl) && $fell(sda);
    endsequence
    sequence s_stop;
        scl && $past(scl) && $rose(sda);
    endsequence
    property p_scl_own;
        !scl |-> scl_m_oe;
    endproperty
    property p_slv_low;
        $changed(sda_s_oe) |-> !scl && !$past(scl) && !$past(scl, 2);
    endproperty
    property p_no_fight;
        sda_s_oe |-> !sda_m_oe;
    endproperty
    property p_stop_idle;
        s_stop |=> (scl && sda) [*8];
    endproperty
    property p_start_hold;
        s_start |=> scl [*4];
    endproperty
    property p_start_free;
        s_start |-> !sda_s_oe;
    endproperty
    property p_high_ph;
        $rose(scl) |=> scl [*8];
    endproperty
    property p_low_ph;
        $fell(scl) |=> !scl [*8];
    endproperty
    a_scl_own: assert property (p_scl_own) else $error("scl low without master drive");
    a_slv_low: assert property (p_slv_low) else $error("slave sda changed outside scl low");
    a_no_fight: assert property (p_no_fight) else $error("master and slave drive sda together");
    a_stop_idle: assert property (p_stop_idle) else $error("bus not idle after stop");
    a_start_hold: assert property (p_start_hold) else $error("scl fell too soon after start");
    a_start_free: assert property (p_start_free) else $error("slave drives sda at start");
    a_high_ph: assert property (p_high_ph) else $error("scl high phase too short");
    a_low_ph: assert property (p_low_ph) else $error("scl low phase too short");
endmodule
`default_nettype wire

// ---- bench/tb_i2c_gain_control_slave.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_i2c_gain_control_slave;
    import igc_pkg::*;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [2:0] p = 3'h0;
    logic req_i = 1'b0;
    logic req_read_i = 1'b0;
    logic [6:0] dev_addr_i = 7'h00;
    logic [7:0] mem_addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic [7:0] ctrl_o, gain_db_o, rdata_o;
    logic mute_o, out_muted_o, sby_o, amp_active_o, bus_idle_o, ready_o, done_o, nack_o;
    logic [2:0] st;
    logic [7:0] wd;
    logic [4:0] gain_code_o;
    logic gain_invalid_o, ctrl_write_o;
    int wr_seen = 0;
    int err_count = 0;
    int checks = 0;
    igc_bus_if bus ();
    igc_slave u_igc_slave (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus(bus), .addr_sel_pin_low_i(p[0]),
        .addr_sel_pin_mid_i(p[1]), .addr_sel_pin_high_i(p[2]), .ctrl_o(ctrl_o), .gain_code_o(gain_code_o),
        .gain_db_o(gain_db_o), .gain_invalid_o(gain_invalid_o), .mute_o(mute_o), .out_muted_o(out_muted_o),
        .standby_supply_current_o(sby_o), .amp_active_o(amp_active_o), .bus_idle_o(bus_idle_o),
        .ctrl_write_o(ctrl_write_o));
    igc_master #(.QUARTER(8)) u_igc_master (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus(bus), .req_i(req_i),
        .req_read_i(req_read_i), .dev_addr_i(dev_addr_i), .mem_addr_i(mem_addr_i), .wdata_i(wdata_i),
        .ready_o(ready_o), .done_o(done_o), .nack_o(nack_o), .rdata_o(rdata_o));
    igc_bus_monitor u_igc_bus_monitor (.clk_i(clk_i), .rst_n_i(rst_n_i), .scl_m_oe(bus.scl_m_oe),
        .sda_m_oe(bus.sda_m_oe), .sda_s_oe(bus.sda_s_oe), .scl(bus.scl), .sda(bus.sda));
    always #2 clk_i = ~clk_i;
    // count register write strobes
    always @(negedge clk_i) begin
        if (ctrl_write_o === 1'b1) begin
            wr_seen <= wr_seen + 1;
        end
    end
    function automatic logic [7:0] exp_db(input logic [4:0] c);
        return 8'(-35 + 3 * int'(c));
    endfunction
    task automatic print_verdict();
        if (err_count == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic rd, input logic [2:0] s, input logic [7:0] ma, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        req_i <= 1'b1;
        req_read_i <= rd;
        dev_addr_i <= {4'ha, s};
        mem_addr_i <= ma;
        wdata_i <= d;
        @(posedge clk_i);
        req_i <= 1'b0;
        do begin
            @(negedge clk_i);
            n++;
        end while (done_o !== 1'b1 && n < 6000);
        chk({7'h0, n < 6000}, 8'h01);
    endtask
    initial begin
        repeat (90000) @(posedge clk_i);
        err_count++;
        print_verdict();
    end
    initial begin
        st = 3'($urandom(80406));
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(negedge clk_i);
        chk(ctrl_o, 8'h80);
        chk({5'h0, out_muted_o, amp_active_o, bus_idle_o}, 8'h05);
        for (int i = 0; i < 6; i++) begin
            st = (i == 0) ? 3'h0 : 3'($urandom_range(7));
            wd = {1'($urandom), 1'($urandom), 1'($urandom), 5'($urandom_range(20))};
            @(posedge clk_i);
            p <= st;
            xfer(1'b0, st, CTRL_ADDR, wd);
            chk(ctrl_o, wd);
            chk(gain_db_o, exp_db(wd[4:0]));
            chk({2'h0, gain_invalid_o, gain_code_o}, {3'h0, wd[4:0]});
            chk({3'h0, out_muted_o, sby_o, mute_o, nack_o, bus_idle_o}, {3'h0, wd[7] | wd[5], wd[7], wd[5], 2'b01});
            xfer(1'b1, st, CTRL_ADDR, 8'h00);
            chk(rdata_o, wd);
            xfer(1'b0, st, 8'($urandom_range(247)), ~wd);
            chk(ctrl_o, wd);
            xfer(1'b1, st, 8'h10, 8'h00);
            chk(rdata_o, READ_OTHER);
            xfer(1'b0, st ^ 3'(1 << (i % 3)), CTRL_ADDR, ~wd);
            chk({nack_o, ctrl_o[6:0]}, {1'b1, wd[6:0]});
        end
        xfer(1'b0, st, CTRL_ADDR, 8'h80);
        xfer(1'b0, st, CTRL_ADDR, 8'h14);
        chk({7'h0, amp_active_o}, 8'h00);
        repeat (TPU_CYCLES - 100) @(negedge clk_i);
        chk({7'h0, amp_active_o}, 8'h00);
        repeat (150) @(negedge clk_i);
        chk({6'h0, amp_active_o, out_muted_o}, 8'h02);
        chk(8'(wr_seen), 8'h08);
        print_verdict();
    end
endmodule
`default_nettype wire

// ---- hdl/igc_bus_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface igc_bus_if;
    logic scl_m_o;
    logic scl_m_oe;
    logic sda_m_o;
    logic sda_m_oe;
    logic sda_s_o;
    logic sda_s_oe;
    logic scl;
    logic sda;

    // open-drain wired-and with pull-ups
    assign scl = scl_m_oe ? scl_m_o : 1'b1;
    assign sda = (sda_m_oe ? sda_m_o : 1'b1) & (sda_s_oe ? sda_s_o : 1'b1);

    modport master(output scl_m_o, output scl_m_oe, output sda_m_o, output sda_m_oe, input scl, input sda);
    modport slave(output sda_s_o, output sda_s_oe, input scl, input sda);
endinterface
`default_nettype wire

// ---- hdl/igc_master.sv ----
`timescale 1ns/1ps
`default_nettype none
module igc_master #(
    parameter int QUARTER = igc_pkg::SCL_QUARTER_CYCLES
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // two-wire bus
    igc_bus_if.master bus,
    // command
    input wire logic req_i,
    input wire logic req_read_i,
    input wire logic [6:0] dev_addr_i,
    input wire logic [7:0] mem_addr_i,
    input wire logic [7:0] wdata_i,
    // answer
    output logic ready_o,
    output logic done_o,
    output logic nack_o,
    output logic [7:0] rdata_o
);
    import igc_pkg::*;

    igc_mst_state_e st_reg;
    igc_mst_state_e st_next;
    igc_item_e kind_reg;
    igc_item_e kind_next;
    logic [QCNT_W-1:0] qcnt_reg;
    logic [QCNT_W-1:0] qcnt_next;
    logic [1:0] ph_reg;
    logic [1:0] ph_next;
    logic [2:0] step_reg;
    logic [2:0] step_next;
    logic [3:0] bit_reg;
    logic [3:0] bit_next;
    logic [7:0] tx_reg;
    logic [7:0] tx_next;
    logic [7:0] rx_reg;
    logic [7:0] rx_next;
    logic scl_oe_reg;
    logic scl_oe_next;
    logic sda_oe_reg;
    logic sda_oe_next;
    logic done_reg;
    logic done_next;
    logic nack_reg;
    logic nack_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic rd_reg;
    logic rd_next;
    logic [6:0] dev_reg;
    logic [6:0] dev_next;
    logic [7:0] mem_reg;
    logic [7:0] mem_next;
    logic [7:0] wd_reg;
    logic [7:0] wd_next;
    logic sda_s;
    logic tick;
    logic item_end;
    logic [9:0] item_w;

    igc_sync #(
        .W(1),
        .RST_VAL(1'b1)
    ) u_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .d_i(bus.sda),
        .q_o(sda_s)
    );

    // transfer program: write is start, dev+w, addr, data, stop;
    // read is start, dev+w, addr, restart, dev+r, data with nack, stop
    function automatic logic [9:0] item(input logic [2:0] s, input logic rd, input logic [6:0] dv,
                                        input logic [7:0] ma, input logic [7:0] wd);
        logic [9:0] r;
        r = {K_STOP, 8'h00};
        case (s)
            3'h0: r = {K_START, 8'h00};
            3'h1: r = {K_WBYTE, dv, 1'b0};
            3'h2: r = {K_WBYTE, ma};
            3'h3: r = rd ? {K_START, 8'h00} : {K_WBYTE, wd};
            3'h4: r = rd ? {K_WBYTE, dv, 1'b1} : {K_STOP, 8'h00};
            3'h5: r = rd ? {K_RBYTE, 8'h00} : {K_STOP, 8'h00};
            default: r = {K_STOP, 8'h00};
        endcase
        return r;
    endfunction

    assign tick = (st_reg == M_BUSY) && (qcnt_reg == '0);

    always_comb begin
        st_next = st_reg;
        kind_next = kind_reg;
        qcnt_next = qcnt_reg;
        ph_next = ph_reg;
        step_next = step_reg;
        bit_next = bit_reg;
        tx_next = tx_reg;
        rx_next = rx_reg;
        scl_oe_next = scl_oe_reg;
        sda_oe_next = sda_oe_reg;
        done_next = 1'b0;
        nack_next = nack_reg;
        rdata_next = rdata_reg;
        rd_next = rd_reg;
        dev_next = dev_reg;
        mem_next = mem_reg;
        wd_next = wd_reg;
        item_end = 1'b0;
        item_w = 10'h000;
        if (st_reg == M_IDLE) begin
            scl_oe_next = 1'b0;
            sda_oe_next = 1'b0;
            if (req_i) begin
                st_next = M_BUSY;
                kind_next = K_START;
                step_next = 3'h0;
                ph_next = 2'h0;
                qcnt_next = QCNT_W'(QUARTER);
                nack_next = 1'b0;
                rd_next = req_read_i;
                dev_next = dev_addr_i;
                mem_next = mem_addr_i;
                wd_next = wdata_i;
            end
        end else if (tick) begin
            qcnt_next = QCNT_W'(QUARTER);
            ph_next = ph_reg + 2'h1;
            case (kind_reg)
                K_START: begin
                    case (ph_reg)
                        2'h0: sda_oe_next = 1'b0;
                        2'h1: scl_oe_next = 1'b0;
                        2'h2: sda_oe_next = 1'b1;
                        default: begin
                            scl_oe_next = 1'b1;
                            item_end = 1'b1;
                        end
                    endcase
                end
                K_STOP: begin
                    case (ph_reg)
                        2'h0: sda_oe_next = 1'b1;
                        2'h1: scl_oe_next = 1'b0;
                        2'h2: sda_oe_next = 1'b0;
                        default: begin
                            st_next = M_IDLE;
                            done_next = 1'b1;
                        end
                    endcase
                end
                default: begin
                    case (ph_reg)
                        2'h0: sda_oe_next = (kind_reg == K_WBYTE) && (bit_reg != 4'h8) && !tx_reg[7];
                        2'h1: scl_oe_next = 1'b0;
                        2'h2: begin
                            if (bit_reg != 4'h8) begin
                                rx_next = {rx_reg[6:0], sda_s};
                            end else if (kind_reg == K_WBYTE && sda_s) begin
                                nack_next = 1'b1;
                            end
                        end
                        default: begin
                            scl_oe_next = 1'b1;
                            tx_next = {tx_reg[6:0], 1'b0};
                            bit_next = bit_reg + 4'h1;
                            // let go of sda with the falling scl so the slave's ack never meets our drive
                            if (bit_reg == 4'h7) begin
                                sda_oe_next = 1'b0;
                            end
                            if (bit_reg == 4'h8) begin
                                item_end = 1'b1;
                                if (kind_reg == K_RBYTE) begin
                                    rdata_next = rx_reg;
                                end
                            end
                        end
                    endcase
                end
            endcase
            if (item_end) begin
                step_next = (nack_next) ? 3'h6 : step_reg + 3'h1;
                item_w = item(step_next, rd_reg, dev_reg, mem_reg, wd_reg);
                kind_next = igc_item_e'(item_w[9:8]);
                tx_next = item_w[7:0];
                bit_next = 4'h0;
            end
        end else begin
            qcnt_next = qcnt_reg - 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_reg <= M_IDLE;
            kind_reg <= K_START;
            qcnt_reg <= '0;
            ph_reg <= 2'h0;
            step_reg <= 3'h0;
            bit_reg <= 4'h0;
            tx_reg <= 8'h00;
            rx_reg <= 8'h00;
            scl_oe_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
            done_reg <= 1'b0;
            nack_reg <= 1'b0;
            rdata_reg <= 8'h00;
            rd_reg <= 1'b0;
            dev_reg <= 7'h00;
            mem_reg <= 8'h00;
            wd_reg <= 8'h00;
        end else begin
            st_reg <= st_next;
            kind_reg <= kind_next;
            qcnt_reg <= qcnt_next;
            ph_reg <= ph_next;
            step_reg <= step_next;
            bit_reg <= bit_next;
            tx_reg <= tx_next;
            rx_reg <= rx_next;
            scl_oe_reg <= scl_oe_next;
            sda_oe_reg <= sda_oe_next;
            done_reg <= done_next;
            nack_reg <= nack_next;
            rdata_reg <= rdata_next;
            rd_reg <= rd_next;
            dev_reg <= dev_next;
            mem_reg <= mem_next;
            wd_reg <= wd_next;
        end
    end

    assign bus.scl_m_o = 1'b0;
    assign bus.scl_m_oe = scl_oe_reg;
    assign bus.sda_m_o = 1'b0;
    assign bus.sda_m_oe = sda_oe_reg;
    assign ready_o = (st_reg == M_IDLE);
    assign done_o = done_reg;
    assign nack_o = nack_reg;
    assign rdata_o = rdata_reg;
endmodule
`default_nettype wire

// ---- hdl/igc_pkg.sv ----
`default_nettype none
package igc_pkg;
    localparam int CLK_PERIOD_NS = 4;
    localparam logic [7:0] CTRL_ADDR = 8'hf8;
    localparam logic [7:0] CTRL_RESET = 8'h80;
    localparam int STANDBY_BIT = 7;
    localparam int DONTCARE_BIT = 6;
    localparam int MUTE_BIT = 5;
    localparam int GAIN_W = 5;
    localparam logic [4:0] GAIN_MAX = 5'h14;
    localparam logic signed [7:0] GAIN_BASE_DB = -8'sd35;
    localparam logic signed [7:0] GAIN_STEP_DB = 8'sd3;
    localparam logic [3:0] DEV_ID_FIXED = 4'ha;
    localparam logic [7:0] READ_OTHER = 8'h00;
    localparam int TPU_NS = 10000;
    localparam int TPU_CYCLES = (TPU_NS / CLK_PERIOD_NS) < 1 ? 1 : (TPU_NS / CLK_PERIOD_NS);
    localparam int PU_W = $clog2(TPU_CYCLES + 1);
    localparam int SCL_PERIOD_NS = 2500;
    localparam int SCL_QUARTER_CYCLES = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
    localparam int QCNT_W = 16;
    localparam logic [4:0] SLV_SYNC_RST = 5'h18;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_DEV = 3'b001,
        S_MADDR = 3'b010,
        S_WDATA = 3'b011,
        S_RDATA = 3'b100
    } igc_slv_state_e;

    typedef enum logic [1:0] {
        K_START = 2'b00,
        K_WBYTE = 2'b01,
        K_RBYTE = 2'b10,
        K_STOP = 2'b11
    } igc_item_e;

    typedef enum logic [1:0] {
        M_IDLE = 2'b00,
        M_BUSY = 2'b01
    } igc_mst_state_e;
endpackage
`default_nettype wire

// ---- hdl/igc_slave.sv ----
// What this block does
// - control register at F8h: standby, x, mute, gain
// - gain code 00h..14h maps -35 to +25 dB
// - register resets to 1000 0000 binary
// - output active within exit delay after standby clears
// - address byte: 7-bit address then direction bit
// - each strap pin sets its own address bit
// - fixed upper address bits are 1010
// - both lines high between stop and start: idle
// - master starts: sda falls while scl high
// - master stops: sda rises while scl high
// - repeated start accepted like a normal start
// - master changes sda only while scl low
// - slave samples sda on scl rising edge
// - slave drives read bit at scl falling edge
// - master releases sda before slave read bits
// - master makes every scl pulse, slave never
// - mute silences output whatever the gain
// - standby mutes output and enters low current
// - master never writes gain codes above 14h
// - write: memory address byte, then data byte
`timescale 1ns/1ps
`default_nettype none
module igc_slave (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // two-wire bus
    igc_bus_if.slave bus,
    // address strap pins
    input wire logic addr_sel_pin_low_i,
    input wire logic addr_sel_pin_mid_i,
    input wire logic addr_sel_pin_high_i,
    // amplifier controls
    output logic [7:0] ctrl_o,
    output logic [igc_pkg::GAIN_W-1:0] gain_code_o,
    output logic signed [7:0] gain_db_o,
    output logic gain_invalid_o,
    output logic mute_o,
    output logic out_muted_o,
    output logic standby_supply_current_o,
    output logic amp_active_o,
    // status
    output logic bus_idle_o,
    output logic ctrl_write_o
);
    import igc_pkg::*;

    logic [4:0] raw_in;
    logic [4:0] sync_in;
    logic scl_s;
    logic sda_s;
    logic [2:0] strap;
    logic scl_d_reg;
    logic sda_d_reg;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    igc_slv_state_e state_reg;
    igc_slv_state_e state_next;
    logic [3:0] bitcnt_reg;
    logic [3:0] bitcnt_next;
    logic [7:0] shift_reg;
    logic [7:0] shift_next;
    logic [7:0] tx_reg;
    logic [7:0] tx_next;
    logic [7:0] ptr_reg;
    logic [7:0] ptr_next;
    logic ack_reg;
    logic ack_next;
    logic sda_oe_reg;
    logic sda_oe_next;
    logic [7:0] ctrl_reg;
    logic [7:0] ctrl_next;
    logic wr_reg;
    logic wr_next;
    logic idle_reg;
    logic idle_next;
    logic [7:0] rd_val;
    logic [PU_W-1:0] pu_cnt_reg;
    logic [PU_W-1:0] pu_cnt_next;
    logic active_reg;
    logic active_next;
    logic muted_reg;
    logic muted_next;
    logic signed [7:0] db_reg;
    logic signed [7:0] db_next;
    logic invalid_reg;
    logic invalid_next;

    assign raw_in = {bus.scl, bus.sda, addr_sel_pin_high_i, addr_sel_pin_mid_i, addr_sel_pin_low_i};

    igc_sync #(
        .W(5),
        .RST_VAL(SLV_SYNC_RST)
    ) u_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .d_i(raw_in),
        .q_o(sync_in)
    );

    assign scl_s = sync_in[4];
    assign sda_s = sync_in[3];
    assign strap = sync_in[2:0];

    // edge and condition detection on filtered lines
    assign scl_rise = scl_s & ~scl_d_reg;
    assign scl_fall = ~scl_s & scl_d_reg;
    assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
    assign stop_det = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

    // read data: the control register or a fixed filler
    assign rd_val = (ptr_reg == CTRL_ADDR) ? ctrl_reg : READ_OTHER;

    // bus protocol engine
    always_comb begin
        state_next = state_reg;
        bitcnt_next = bitcnt_reg;
        shift_next = shift_reg;
        tx_next = tx_reg;
        ptr_next = ptr_reg;
        ack_next = ack_reg;
        sda_oe_next = sda_oe_reg;
        ctrl_next = ctrl_reg;
        wr_next = 1'b0;
        idle_next = idle_reg;
        if (start_det) begin
            state_next = S_DEV;
            bitcnt_next = 4'h0;
            ack_next = 1'b0;
            sda_oe_next = 1'b0;
            idle_next = 1'b0;
        end else if (stop_det) begin
            state_next = S_IDLE;
            ack_next = 1'b0;
            sda_oe_next = 1'b0;
            idle_next = 1'b1;
        end else if (scl_rise) begin
            if (state_reg == S_RDATA) begin
                if (bitcnt_reg == 4'h8) begin
                    if (sda_s) begin
                        state_next = S_IDLE;
                    end else begin
                        bitcnt_next = 4'h0;
                        tx_next = rd_val;
                    end
                end else begin
                    bitcnt_next = bitcnt_reg + 4'h1;
                end
            end else if (state_reg != S_IDLE && bitcnt_reg != 4'h8) begin
                shift_next = {shift_reg[6:0], sda_s};
                bitcnt_next = bitcnt_reg + 4'h1;
            end
        end else if (scl_fall) begin
            if (ack_reg) begin
                ack_next = 1'b0;
                sda_oe_next = 1'b0;
                bitcnt_next = 4'h0;
                case (state_reg)
                    S_DEV: begin
                        if (shift_reg[0]) begin
                            state_next = S_RDATA;
                            sda_oe_next = ~rd_val[7];
                            tx_next = {rd_val[6:0], 1'b0};
                        end else begin
                            state_next = S_MADDR;
                        end
                    end
                    S_MADDR: begin
                        state_next = S_WDATA;
                    end
                    default: begin
                    end
                endcase
            end else if (state_reg == S_RDATA) begin
                if (bitcnt_reg == 4'h8) begin
                    sda_oe_next = 1'b0;
                end else begin
                    sda_oe_next = ~tx_reg[7];
                    tx_next = {tx_reg[6:0], 1'b0};
                end
            end else if (bitcnt_reg == 4'h8) begin
                case (state_reg)
                    S_DEV: begin
                        if (shift_reg[7:1] == {DEV_ID_FIXED, strap}) begin
                            ack_next = 1'b1;
                            sda_oe_next = 1'b1;
                        end else begin
                            state_next = S_IDLE;
                        end
                    end
                    S_MADDR: begin
                        ack_next = 1'b1;
                        sda_oe_next = 1'b1;
                        ptr_next = shift_reg;
                    end
                    S_WDATA: begin
                        ack_next = 1'b1;
                        sda_oe_next = 1'b1;
                        if (ptr_reg == CTRL_ADDR) begin
                            ctrl_next = shift_reg;
                            wr_next = 1'b1;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // amplifier control decode
    always_comb begin
        pu_cnt_next = pu_cnt_reg;
        if (ctrl_reg[STANDBY_BIT]) begin
            pu_cnt_next = '0;
        end else if (pu_cnt_reg != PU_W'(TPU_CYCLES)) begin
            pu_cnt_next = pu_cnt_reg + 1'b1;
        end
        active_next = ~ctrl_reg[STANDBY_BIT] & ~ctrl_reg[MUTE_BIT] & (pu_cnt_next == PU_W'(TPU_CYCLES));
        muted_next = ctrl_reg[MUTE_BIT] | ctrl_reg[STANDBY_BIT];
        db_next = GAIN_BASE_DB + $signed({3'b000, ctrl_reg[GAIN_W-1:0]}) * GAIN_STEP_DB;
        invalid_next = ctrl_reg[GAIN_W-1:0] > GAIN_MAX;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
            state_reg <= S_IDLE;
            bitcnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            tx_reg <= 8'h00;
            ptr_reg <= 8'h00;
            ack_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
            ctrl_reg <= CTRL_RESET;
            wr_reg <= 1'b0;
            idle_reg <= 1'b1;
            pu_cnt_reg <= '0;
            active_reg <= 1'b0;
            muted_reg <= 1'b1;
            db_reg <= GAIN_BASE_DB;
            invalid_reg <= 1'b0;
        end else begin
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
            state_reg <= state_next;
            bitcnt_reg <= bitcnt_next;
            shift_reg <= shift_next;
            tx_reg <= tx_next;
            ptr_reg <= ptr_next;
            ack_reg <= ack_next;
            sda_oe_reg <= sda_oe_next;
            ctrl_reg <= ctrl_next;
            wr_reg <= wr_next;
            idle_reg <= idle_next;
            pu_cnt_reg <= pu_cnt_next;
            active_reg <= active_next;
            muted_reg <= muted_next;
            db_reg <= db_next;
            invalid_reg <= invalid_next;
        end
    end

    // the slave only ever pulls sda low, never scl
    assign bus.sda_s_o = 1'b0;
    assign bus.sda_s_oe = sda_oe_reg;
    assign ctrl_o = ctrl_reg;
    assign gain_code_o = ctrl_reg[GAIN_W-1:0];
    assign gain_db_o = db_reg;
    assign gain_invalid_o = invalid_reg;
    assign mute_o = ctrl_reg[MUTE_BIT];
    assign out_muted_o = muted_reg;
    assign standby_supply_current_o = ctrl_reg[STANDBY_BIT];
    assign amp_active_o = active_reg;
    assign bus_idle_o = idle_reg;
    assign ctrl_write_o = wr_reg;
endmodule
`default_nettype wire

// ---- hdl/igc_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module igc_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // raw and filtered levels
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            logic ff1_reg;
            logic ff2_reg;
            logic ff3_reg;
            logic q_reg;
            logic q_next;
            // a change counts once the second and third stages agree
            always_comb begin
                q_next = (ff2_reg == ff3_reg) ? ff3_reg : q_reg;
            end
            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    ff1_reg <= RST_VAL[g];
                    ff2_reg <= RST_VAL[g];
                    ff3_reg <= RST_VAL[g];
                    q_reg <= RST_VAL[g];
                end else begin
                    ff1_reg <= d_i[g];
                    ff2_reg <= ff1_reg;
                    ff3_reg <= ff2_reg;
                    q_reg <= q_next;
                end
            end
            assign q_o[g] = q_reg;
        end
    endgenerate
endmodule
`default_nettype wire
